//--- icc_ctrl.sv
// Input capture control: AXI4-Lite registers, prescaler, edge timing
// Assumes capture pin and transfer-end pulse synchronous to sys_clk
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/100ps
`include "icc_defines.svh"

module icc_ctrl (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Register bus
  input wire icc_pkg::icc_axi_req_t axi_req,
  output icc_pkg::icc_axi_rsp_t axi_rsp,
  // Capture pin and transfer end
  input wire logic capture_pin,
  input wire logic xfer_done,
  // Status outputs
  output logic pin_open_drain,
  output logic capture_enabled
);
  import icc_pkg::*;

  icc_state_t st;
  icc_state_t n;
  logic do_wr;
  logic do_rd;
  logic [7:0] wa;
  logic [31:0] wd;

  function automatic logic [31:0] strb_mask(input logic [3:0] s);
    strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction : strb_mask

  function automatic logic [13:0] ps_limit(input logic [3:0] p);
    // Divide by one when the field is zero
    if (p == 4'h0) begin
      ps_limit = 14'h0000;
    end else begin
      ps_limit = 14'((15'h0001 << (p - 4'h1)) - 15'h0001);
    end
  endfunction : ps_limit

  function automatic icc_edge_t edge_kind(input logic [1:0] m);
    if (m == 2'b00) begin
      edge_kind = ICC_EDGE_ANY;
    end else if (m[1]) begin
      edge_kind = ICC_EDGE_RISE;
    end else begin
      edge_kind = ICC_EDGE_FALL;
    end
  endfunction : edge_kind

  function automatic logic wr_ok(input logic [7:0] a);
    if (a == `ICC_OFS_OD_EN || a == `ICC_OFS_OD_DIS) begin
      wr_ok = 1'b1;
    end else if (a == `ICC_OFS_CLK_EN || a == `ICC_OFS_CLK_DIS) begin
      wr_ok = 1'b1;
    end else if (a == `ICC_OFS_CMD || a == `ICC_OFS_MODE) begin
      wr_ok = 1'b1;
    end else if (a == `ICC_OFS_CLR) begin
      wr_ok = 1'b1;
    end else begin
      wr_ok = 1'b0;
    end
  endfunction : wr_ok

  function automatic icc_state_t icc_init();
    icc_init = '0;
    icc_init.bus.awrdy = 1'b1;
    icc_init.bus.wrdy = 1'b1;
    icc_init.bus.ardy = 1'b1;
    icc_init.armed = 1'b1;
    icc_init.mode = `ICC_MODE_RST;
  endfunction : icc_init

  icc_edge_t ek;
  logic rise;
  logic fall;
  logic ev;
  logic active;
  logic tick;
  logic take_ev;
  logic [15:0] cmax;
  logic [15:0] dur;
  logic [31:0] rd;
  logic [1:0] rr;
  icc_state_t r;

  always_comb begin
    n = st;
    r = icc_init();
    wa = st.bus.awaddr;
    wd = st.bus.wdata;
    rd = 32'h0000_0000;
    rr = `ICC_RESP_OKAY;
    // Bus channels, address and data taken in either order
    if (axi_req.awvalid && st.bus.awrdy) begin
      n.bus.aw_have = 1'b1;
      n.bus.awaddr = axi_req.awaddr;
    end
    if (axi_req.wvalid && st.bus.wrdy) begin
      n.bus.w_have = 1'b1;
      n.bus.wdata = axi_req.wdata & strb_mask(axi_req.wstrb);
    end
    if (st.bus.bvalid && axi_req.bready) begin
      n.bus.bvalid = 1'b0;
    end
    do_wr = st.bus.aw_have && st.bus.w_have && !st.bus.bvalid;
    if (do_wr) begin
      n.bus.aw_have = 1'b0;
      n.bus.w_have = 1'b0;
      n.bus.bvalid = 1'b1;
      n.bus.bresp = wr_ok(wa) ? `ICC_RESP_OKAY : `ICC_RESP_SLVERR;
    end
    if (st.bus.rvalid && axi_req.rready) begin
      n.bus.rvalid = 1'b0;
    end
    do_rd = axi_req.arvalid && st.bus.ardy;
    if (axi_req.araddr == `ICC_OFS_OD_STAT) begin
      rd[`ICC_BIT_PIN] = st.od;
    end else if (axi_req.araddr == `ICC_OFS_PM_STAT) begin
      rd[`ICC_BIT_PIN_IO_CLK] = st.pin_io_clock;
      rd[`ICC_BIT_MEASURE_CLK] = st.measure_clock;
    end else if (axi_req.araddr == `ICC_OFS_MODE) begin
      rd[7:0] = st.mode;
    end else if (axi_req.araddr == `ICC_OFS_STAT) begin
      rd[`ICC_BIT_F_END] = st.f_end;
      rd[`ICC_BIT_F_OVR] = st.f_ovr;
      rd[`ICC_BIT_F_OFL] = st.f_ofl;
      rd[`ICC_BIT_F_RDY] = st.f_rdy;
      rd[`ICC_BIT_ENS] = st.en;
      rd[`ICC_BIT_PIN] = st.f_pin;
    end else if (axi_req.araddr == `ICC_OFS_DATA) begin
      rd[15:0] = st.data;
    end else begin
      rr = `ICC_RESP_SLVERR;
    end
    if (do_rd) begin
      n.bus.rvalid = 1'b1;
      n.bus.rdata = rd;
      n.bus.rresp = rr;
      if (axi_req.araddr == `ICC_OFS_DATA) begin
        n.f_rdy = 1'b0;
      end
    end
    // Register writes; flag clears come before the sets below
    if (do_wr) begin
      if (wa == `ICC_OFS_OD_EN && wd[`ICC_BIT_PIN]) begin
        n.od = 1'b1;
      end else if (wa == `ICC_OFS_OD_DIS && wd[`ICC_BIT_PIN]) begin
        n.od = 1'b0;
      end else if (wa == `ICC_OFS_CLK_EN) begin
        n.pin_io_clock = st.pin_io_clock | wd[`ICC_BIT_PIN_IO_CLK];
        n.measure_clock = st.measure_clock | wd[`ICC_BIT_MEASURE_CLK];
      end else if (wa == `ICC_OFS_CLK_DIS) begin
        n.pin_io_clock = st.pin_io_clock & ~wd[`ICC_BIT_PIN_IO_CLK];
        n.measure_clock = st.measure_clock & ~wd[`ICC_BIT_MEASURE_CLK];
      end else if (wa == `ICC_OFS_CMD) begin
        if (wd[`ICC_BIT_EN]) begin
          n.en = 1'b1;
        end
        if (wd[`ICC_BIT_DIS]) begin
          n.en = 1'b0;
        end
      end else if (wa == `ICC_OFS_MODE) begin
        n.mode = wd[7:0];
      end else if (wa == `ICC_OFS_CLR) begin
        n.f_end = st.f_end & ~wd[`ICC_BIT_F_END];
        n.f_ovr = st.f_ovr & ~wd[`ICC_BIT_F_OVR];
        n.f_ofl = st.f_ofl & ~wd[`ICC_BIT_F_OFL];
        n.f_pin = st.f_pin & ~wd[`ICC_BIT_PIN];
      end
    end
    // Edge timing on the counter clock enable
    rise = capture_pin && !st.pin_prev;
    fall = !capture_pin && st.pin_prev;
    ek = edge_kind(st.mode[5:4]);
    ev = (ek == ICC_EDGE_ANY) ? (rise | fall) :
         ((ek == ICC_EDGE_RISE) ? rise : fall);
    cmax = st.mode[5] ? `ICC_MAX_PER : `ICC_MAX_LVL;
    active = st.en && st.measure_clock && st.armed;
    tick = active && (st.ps_cnt >= ps_limit(st.mode[3:0]));
    // Count the tick that lands on the closing edge as well
    if (tick && (st.cnt < cmax)) begin
      dur = st.cnt + 16'h0001;
    end else begin
      dur = st.cnt;
    end
    take_ev = active && ev && st.started;
    n.pin_prev = capture_pin;
    if (st.pin_io_clock && (rise || fall)) begin
      n.f_pin = 1'b1;
    end
    if (xfer_done) begin
      n.f_end = 1'b1;
    end
    if (!st.mode[7]) begin
      n.armed = 1'b1;
    end
    if (active && ev) begin
      n.started = 1'b1;
      n.cnt = 16'h0000;
      n.ps_cnt = 14'h0000;
      if (take_ev) begin
        if (st.f_rdy) begin
          n.f_ovr = 1'b1;
        end
        if (st.mode[6] || !(st.f_ovr || st.f_rdy)) begin
          // Level modes keep the level held in the top bit
          n.data = st.mode[5] ? dur :
                   {st.pin_prev, dur[14:0]};
          n.f_rdy = 1'b1;
        end
        if (st.mode[7]) begin
          n.armed = 1'b0;
        end
      end
    end else if (tick) begin
      n.ps_cnt = 14'h0000;
      if (st.cnt >= cmax) begin
        n.f_ofl = 1'b1;
      end else begin
        n.cnt = st.cnt + 16'h0001;
      end
    end else if (active) begin
      n.ps_cnt = st.ps_cnt + 14'h0001;
    end
    if (do_wr && wa == `ICC_OFS_CMD && wd[`ICC_BIT_START]) begin
      n.armed = 1'b1;
      n.started = 1'b0;
      n.cnt = 16'h0000;
      n.ps_cnt = 14'h0000;
    end
    // Soft reset keeps the bus handshake and the clock gating
    r.bus = n.bus;
    r.pin_io_clock = n.pin_io_clock;
    r.measure_clock = n.measure_clock;
    r.pin_prev = capture_pin;
    if (do_wr && wa == `ICC_OFS_CMD && wd[`ICC_BIT_SOFT_RESET]) begin
      n = r;
    end
    n.bus.awrdy = !n.bus.aw_have;
    n.bus.wrdy = !n.bus.w_have;
    n.bus.ardy = !n.bus.rvalid;
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      st <= icc_init();
    end else begin
      st <= n;
    end
  end

  always_comb begin
    axi_rsp.awready = st.bus.awrdy;
    axi_rsp.wready = st.bus.wrdy;
    axi_rsp.bresp = st.bus.bresp;
    axi_rsp.bvalid = st.bus.bvalid;
    axi_rsp.arready = st.bus.ardy;
    axi_rsp.rdata = st.bus.rdata;
    axi_rsp.rresp = st.bus.rresp;
    axi_rsp.rvalid = st.bus.rvalid;
    pin_open_drain = st.od;
    capture_enabled = st.en;
  end

  logic cmd_wr;
  assign cmd_wr = do_wr && (wa == `ICC_OFS_CMD);

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);

  a_od_clear: assert property (
    do_wr && wa == `ICC_OFS_OD_DIS && wd[`ICC_BIT_PIN] |=> !pin_open_drain)
    else $error("open drain not cleared");

  a_od_read: assert property (
    do_rd && axi_req.araddr == `ICC_OFS_OD_STAT
    |=> axi_rsp.rdata[`ICC_BIT_PIN] == $past(st.od))
    else $error("open drain status wrong");

  a_clk_enable: assert property (
    do_wr && wa == `ICC_OFS_CLK_EN && wd[`ICC_BIT_MEASURE_CLK]
    |=> st.measure_clock)
    else $error("capture clock not enabled");

  a_dis_wins: assert property (
    cmd_wr && wd[`ICC_BIT_DIS] && !wd[`ICC_BIT_SOFT_RESET]
    |=> !capture_enabled [*2])
    else $error("disable did not win");

  a_soft_reset_keep: assert property (
    cmd_wr && wd[`ICC_BIT_SOFT_RESET] |=> st.mode == `ICC_MODE_RST &&
    st.pin_io_clock == $past(n.pin_io_clock) && !capture_enabled)
    else $error("soft reset effect wrong");

  a_one_shot: assert property (
    take_ev && st.mode[7] && !cmd_wr |=> !st.armed ##1 !take_ev)
    else $error("one shot did not halt");

  a_rdy_clear: assert property (
    do_rd && axi_req.araddr == `ICC_OFS_DATA && !take_ev
    && !(cmd_wr && wd[`ICC_BIT_SOFT_RESET]) |=> !st.f_rdy)
    else $error("read did not clear ready");

  a_no_overwrite: assert property (
    take_ev && !st.mode[6] && st.f_ovr |=> $stable(st.data))
    else $error("data written after overrun");

  a_saturate: assert property (
    tick && !ev && st.cnt >= cmax && !cmd_wr |=> st.f_ofl && $stable(st.cnt))
    else $error("counter did not saturate");

  a_clr_ovr: assert property (
    do_wr && wa == `ICC_OFS_CLR && wd[`ICC_BIT_F_OVR] && !take_ev |=> !st.f_ovr)
    else $error("overrun not cleared");

  a_clk_disable: assert property (
    do_wr && wa == `ICC_OFS_CLK_DIS && wd[`ICC_BIT_MEASURE_CLK]
    |=> !st.measure_clock)
    else $error("capture clock not disabled");

  a_pin_io_read: assert property (
    do_rd && axi_req.araddr == `ICC_OFS_PM_STAT
    |=> axi_rsp.rdata[`ICC_BIT_PIN_IO_CLK] == $past(st.pin_io_clock))
    else $error("pin clock status wrong");

  a_measure_read: assert property (
    do_rd && axi_req.araddr == `ICC_OFS_PM_STAT
    |=> axi_rsp.rdata[`ICC_BIT_MEASURE_CLK] == $past(st.measure_clock))
    else $error("capture clock status wrong");

  a_enable_set: assert property (
    cmd_wr && wd[`ICC_BIT_EN] && !wd[`ICC_BIT_DIS]
    && !wd[`ICC_BIT_SOFT_RESET] |=> capture_enabled)
    else $error("enable not taken");

  a_start_rearm: assert property (
    cmd_wr && wd[`ICC_BIT_START] && !wd[`ICC_BIT_SOFT_RESET]
    |=> st.armed && !st.started && st.cnt == 16'h0000)
    else $error("start did not rearm");

  a_keep_writing: assert property (
    take_ev && st.mode[6] && !cmd_wr
    |=> st.f_rdy && st.data[14:0] == $past(dur[14:0]))
    else $error("data not overwritten");

  a_continuous: assert property (
    take_ev && !st.mode[7] && !do_wr |=> st.armed && st.started)
    else $error("continuous capture halted");

  a_overrun_set: assert property (
    take_ev && st.f_rdy && !cmd_wr |=> st.f_ovr)
    else $error("overrun not flagged");

  a_prescale: assert property (
    tick && !do_wr && st.mode[3:0] == 4'h2 |=> !tick)
    else $error("prescaler tick too soon");

  a_ofl_clear: assert property (
    do_wr && wa == `ICC_OFS_CLR && wd[`ICC_BIT_F_OFL] && !tick
    |=> !st.f_ofl)
    else $error("overflow not cleared");

endmodule : icc_ctrl

//--- icc_defines.svh
// Register offsets, bit positions, reset values and limits
// Assumes inclusion by bare name from the capture control design files
`ifndef ICC_DEFINES_SVH
`define ICC_DEFINES_SVH

`define ICC_OFS_OD_EN 8'h40
`define ICC_OFS_OD_DIS 8'h44
`define ICC_OFS_OD_STAT 8'h48
`define ICC_OFS_CLK_EN 8'h50
`define ICC_OFS_CLK_DIS 8'h54
`define ICC_OFS_PM_STAT 8'h58
`define ICC_OFS_CMD 8'h60
`define ICC_OFS_MODE 8'h64
`define ICC_OFS_CLR 8'h6c
`define ICC_OFS_STAT 8'h70
`define ICC_OFS_DATA 8'h80

`define ICC_BIT_PIN 16
`define ICC_BIT_PIN_IO_CLK 0
`define ICC_BIT_MEASURE_CLK 1
`define ICC_BIT_SOFT_RESET 0
`define ICC_BIT_EN 1
`define ICC_BIT_DIS 2
`define ICC_BIT_START 3
`define ICC_BIT_ENS 8
`define ICC_BIT_F_END 0
`define ICC_BIT_F_OVR 1
`define ICC_BIT_F_OFL 2
`define ICC_BIT_F_RDY 3

`define ICC_MODE_RST 8'h00
`define ICC_MAX_LVL 16'h7fff
`define ICC_MAX_PER 16'hffff
`define ICC_RESP_OKAY 2'b00
`define ICC_RESP_SLVERR 2'b10

`endif

//--- icc_pkg.sv
// Types of the input capture control block
// Assumes an AXI4-Lite master with 8-bit byte addresses
package icc_pkg;

  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } icc_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } icc_axi_rsp_t;

  typedef enum logic [1:0] {
    ICC_EDGE_ANY,
    ICC_EDGE_RISE,
    ICC_EDGE_FALL
  } icc_edge_t;

  typedef struct packed {
    logic awrdy;
    logic wrdy;
    logic ardy;
    logic aw_have;
    logic w_have;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } icc_bus_t;

  typedef struct packed {
    icc_bus_t bus;
    logic pin_io_clock;
    logic measure_clock;
    logic od;
    logic en;
    logic armed;
    logic started;
    logic [7:0] mode;
    logic [13:0] ps_cnt;
    logic [15:0] cnt;
    logic pin_prev;
    logic [15:0] data;
    logic f_end;
    logic f_ovr;
    logic f_ofl;
    logic f_rdy;
    logic f_pin;
  } icc_state_t;

endpackage : icc_pkg

//--- icc_pin_src.sv
// Behavioural source driving the capture input pin
// Assumes the pin is sampled on the rising edge of sys_clk
`timescale 1ns/100ps
module icc_pin_src (
  // Clock
  input wire logic sys_clk,
  // Waveform control
  input wire logic run,
  input wire logic [15:0] hi_len,
  input wire logic [15:0] lo_len,
  // Pin
  output logic capture_pin
);
  logic [15:0] cnt_reg;
  initial begin
    capture_pin = 1'b0;
    cnt_reg = 16'h1;
  end
  // Each level lasts its programmed number of cycles; idle is low
  always @(posedge sys_clk) begin
    if (!run) begin
      capture_pin <= 1'b0;
      cnt_reg <= 16'h1;
    end else if (cnt_reg >= (capture_pin ? hi_len : lo_len)) begin
      capture_pin <= ~capture_pin;
      cnt_reg <= 16'h1;
    end else begin
      cnt_reg <= cnt_reg + 16'h1;
    end
  end
endmodule : icc_pin_src

//--- icc_tb.sv
// Self-checking bench for the input capture control block
// Assumes icc_pkg, icc_ctrl and icc_pin_src are compiled first
`timescale 1ns/100ps
module testbench;
  import icc_pkg::*;
  localparam logic [1:0] rok = 2'b00;
  localparam logic [1:0] rerr = 2'b10;
  logic sys_clk, rstn, xfer_done, run, capture_pin;
  logic pin_open_drain, capture_enabled;
  logic [15:0] hi_len, lo_len;
  icc_axi_req_t req;
  icc_axi_rsp_t rsp;
  int fails, checked;

  icc_ctrl icc_ctrl_i (.sys_clk(sys_clk), .rstn(rstn), .axi_req(req),
    .axi_rsp(rsp), .capture_pin(capture_pin), .xfer_done(xfer_done),
    .pin_open_drain(pin_open_drain), .capture_enabled(capture_enabled));
  icc_pin_src icc_pin_src_i (.sys_clk(sys_clk), .run(run),
    .hi_len(hi_len), .lo_len(lo_len), .capture_pin(capture_pin));

  task report_and_stop;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask : chk

  task tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick

  task wrc(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    bit aw;
    bit w;
    aw = 1;
    w = 1;
    req.awaddr <= a;
    req.wdata <= d;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    while (aw || w) begin
      @(posedge sys_clk);
      if (aw && rsp.awready === 1'b1) begin
        aw = 0;
        req.awvalid <= 1'b0;
      end
      if (w && rsp.wready === 1'b1) begin
        w = 0;
        req.wvalid <= 1'b0;
      end
    end
    do @(posedge sys_clk); while (rsp.bvalid !== 1'b1);
    chk($sformatf("bresp %h", a), {30'h0, er}, {30'h0, rsp.bresp});
  endtask : wrc

  task rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er,
           input logic [31:0] m = 32'hffffffff);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    do @(posedge sys_clk); while (rsp.arready !== 1'b1);
    req.arvalid <= 1'b0;
    do @(posedge sys_clk); while (rsp.rvalid !== 1'b1);
    chk($sformatf("rdata %h", a), e & m, rsp.rdata & m);
    chk($sformatf("rresp %h", a), {30'h0, er}, {30'h0, rsp.rresp});
  endtask : rdc

  task arm(input logic [7:0] m, input logic [15:0] h, input logic [15:0] l);
    wrc(8'h60, 32'h1, rok);
    wrc(8'h64, {24'h0, m}, rok);
    wrc(8'h60, 32'ha, rok);
    hi_len <= h;
    lo_len <= l;
    run <= 1'b1;
  endtask : arm

  task t_reset;
    rdc(8'h58, 32'h0, rok);
    rdc(8'h48, 32'h0, rok);
    rdc(8'h64, 32'h0, rok);
    rdc(8'h70, 32'h0, rok);
    rdc(8'h04, 32'h0, rerr);
    rdc(8'h60, 32'h0, rerr);
    wrc(8'h48, 32'h10000, rerr);
    $display("done: reset");
  endtask : t_reset

  task t_od;
    wrc(8'h40, 32'h10000, rok);
    rdc(8'h48, 32'h10000, rok);
    chk("pin_open_drain", 32'h1, {31'h0, pin_open_drain});
    wrc(8'h44, 32'h0, rok);
    rdc(8'h48, 32'h10000, rok);
    wrc(8'h44, 32'h10000, rok);
    rdc(8'h48, 32'h0, rok);
    chk("pin_open_drain", 32'h0, {31'h0, pin_open_drain});
    $display("done: open drain");
  endtask : t_od

  task t_clk;
    wrc(8'h50, 32'h1, rok);
    rdc(8'h58, 32'h1, rok);
    wrc(8'h50, 32'h2, rok);
    rdc(8'h58, 32'h3, rok);
    wrc(8'h54, 32'h0, rok);
    rdc(8'h58, 32'h3, rok);
    wrc(8'h54, 32'h1, rok);
    rdc(8'h58, 32'h2, rok);
    wrc(8'h64, 32'ha5, rok);
    rdc(8'h64, 32'ha5, rok);
    wrc(8'h40, 32'h10000, rok);
    wrc(8'h60, 32'h2, rok);
    wrc(8'h60, 32'h1, rok);
    rdc(8'h58, 32'h2, rok);
    rdc(8'h64, 32'h0, rok);
    rdc(8'h48, 32'h0, rok);
    rdc(8'h70, 32'h0, rok);
    $display("done: clocks and soft reset");
  endtask : t_clk

  task t_cmd;
    wrc(8'h60, 32'h2, rok);
    rdc(8'h70, 32'h100, rok);
    chk("capture_enabled", 32'h1, {31'h0, capture_enabled});
    wrc(8'h60, 32'h0, rok);
    rdc(8'h70, 32'h100, rok);
    wrc(8'h60, 32'h6, rok);
    rdc(8'h70, 32'h0, rok);
    wrc(8'h60, 32'h2, rok);
    wrc(8'h60, 32'h4, rok);
    chk("capture_enabled", 32'h0, {31'h0, capture_enabled});
    $display("done: commands");
  endtask : t_cmd

  task t_modes;
    logic [7:0] md [5];
    logic [15:0] ex [5];
    md = '{8'h80, 8'h90, 8'ha0, 8'ha2, 8'ha3};
    ex = '{16'h800c, 16'h0014, 16'h0014, 16'h000a, 16'h0005};
    for (int i = 0; i < 5; i++) begin
      arm(md[i], 16'd12, 16'd8);
      tick(60);
      rdc(8'h70, 32'h108, rok);
      rdc(8'h80, {16'h0, ex[i]}, rok, i == 1 ? 32'h7fff : 32'hffff);
      rdc(8'h70, 32'h100, rok);
      tick(60);
      rdc(8'h70, 32'h100, rok);
      wrc(8'h60, 32'h8, rok);
      tick(60);
      rdc(8'h70, 32'h108, rok);
      run <= 1'b0;
    end
    $display("done: modes, prescaler, single measure");
  endtask : t_modes

  task t_over(input bit pol);
    arm({1'b0, pol, 6'h20}, 16'd12, 16'd8);
    tick(60);
    hi_len <= 16'd6;
    lo_len <= 16'd6;
    tick(100);
    run <= 1'b0;
    tick(2);
    rdc(8'h70, 32'h10a, rok);
    rdc(8'h80, pol ? 32'hc : 32'h14, rok);
    $display("done: overrun policy %0d", pol);
  endtask : t_over

  task t_flags;
    wrc(8'h60, 32'h4, rok);
    wrc(8'h50, 32'h1, rok);
    run <= 1'b1;
    xfer_done <= 1'b1;
    tick(1);
    xfer_done <= 1'b0;
    tick(20);
    run <= 1'b0;
    tick(2);
    rdc(8'h70, 32'h10003, rok);
    wrc(8'h6c, 32'h10006, rok);
    rdc(8'h70, 32'h1, rok);
    wrc(8'h6c, 32'h0, rok);
    rdc(8'h70, 32'h1, rok);
    wrc(8'h6c, 32'h1, rok);
    rdc(8'h70, 32'h0, rok);
    wrc(8'h54, 32'h1, rok);
    $display("done: flag clearing");
  endtask : t_flags

  task t_ovf;
    arm(8'h00, 16'd33000, 16'd8);
    tick(33012);
    run <= 1'b0;
    tick(2);
    rdc(8'h70, 32'h10c, rok);
    rdc(8'h80, 32'hffff, rok);
    wrc(8'h6c, 32'h4, rok);
    rdc(8'h70, 32'h100, rok);
    $display("done: saturation");
  endtask : t_ovf

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  initial begin
    tick(60000);
    fails++;
    report_and_stop;
  end

  initial begin
    rstn = 1'b0;
    xfer_done = 1'b0;
    run = 1'b0;
    hi_len = 16'd12;
    lo_len = 16'd8;
    req = '0;
    req.wstrb = 4'hf;
    req.bready = 1'b1;
    req.rready = 1'b1;
    tick(2);
    rstn <= 1'b1;
    t_reset;
    t_od;
    t_clk;
    t_cmd;
    t_modes;
    t_over(1'b0);
    t_over(1'b1);
    t_flags;
    t_ovf;
    report_and_stop;
  end
endmodule : testbench
